// ==== rtb_rx_bus.sv ====
// Receive telecom bus input port: samples the byte-wide bus on falling
// edges of the link clock, checks parity, tracks path AIS per tributary.
// Assumes all bus pins are asynchronous to clk_sys; link clock is slow
// enough (19.44 MHz against 200 MHz) for edge detection by oversampling.
//
// Functional notes
// - Every bus input is taken on a falling edge of the bus clock only.
// - The bus clock is ignored whenever the telecom bus is disabled.
// - A byte with the payload indicator low is treated as overhead.
// - A byte with the payload indicator high is treated as payload.
// - The phase marker pin role depends on bus enable and APS enable.
// - One parity setting covers the eight data bits only.
// - The other covers data, payload indicator and marker, even or odd.
// - Coverage and sense come from the control register at 0x0137.
// - An alarm on a byte declares path AIS for that byte's tributary.
// - Payload APS pin roles are allowed only in ATM UNI or PPP mode.
// - One data byte is captured per falling edge of the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtb_params.svh"

module rtb_rx_bus
  import rtb_pkg::*;
#(
  parameter int NUM_TRIB = `RTB_NUM_TRIB
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic rx_bus_clock,
  input wire logic [7:0] rx_bus_data,
  input wire logic rx_payload_indicator,
  input wire logic rx_frame_phase_marker,
  input wire logic rx_bus_parity_in,
  input wire logic rx_bus_alarm,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`RTB_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [7:0] byte_data,
  output logic byte_is_payload,
  output logic byte_phase_marker,
  output logic byte_alarm,
  output logic [NUM_TRIB-1:0] path_alarm_indication,
  output logic aps_role_active
);

  if (NUM_TRIB != `RTB_NUM_TRIB) begin : g_bad_trib
    $error("rtb_rx_bus: tributary count must match the STS-3 structure");
  end

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam int PW = 13;
  wire logic [PW-1:0] pins_raw;
  logic [PW-1:0] pins_meta_r;
  logic [PW-1:0] pins_sync_r;
  logic clk_prev_r;

  assign pins_raw = {rx_bus_clock, rx_bus_alarm, rx_bus_parity_in,
                     rx_frame_phase_marker, rx_payload_indicator,
                     rx_bus_data};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pins_meta_r <= '0;
      pins_sync_r <= '0;
      clk_prev_r <= 1'b0;
    end else if (ce) begin
      pins_meta_r <= pins_raw;
      pins_sync_r <= pins_meta_r;
      clk_prev_r <= pins_sync_r[PW-1];
    end
  end

  wire logic [7:0] s_data;
  wire logic s_pl;
  wire logic s_mark;
  wire logic s_par;
  wire logic s_alarm;
  wire logic s_clk;

  assign s_data = pins_sync_r[7:0];
  assign s_pl = pins_sync_r[8];
  assign s_mark = pins_sync_r[9];
  assign s_par = pins_sync_r[10];
  assign s_alarm = pins_sync_r[11];
  assign s_clk = pins_sync_r[PW-1];

  // --------------------------------------------------------------------
  // Control and mode decode
  // --------------------------------------------------------------------
  logic [7:0] ctrl_r;
  wire logic bus_en;
  wire logic par_odd;
  wire logic par_all;
  wire logic aps_en;
  wire rtb_mode_t mode;
  wire logic aps_allowed;
  wire logic aps_role;
  wire logic bus_live;

  assign bus_en = ctrl_r[`RTB_CTRL_BUS_EN];
  assign par_odd = ctrl_r[`RTB_CTRL_PAR_ODD];
  assign par_all = ctrl_r[`RTB_CTRL_PAR_ALL];
  assign aps_en = ctrl_r[`RTB_CTRL_APS_EN];
  assign mode = rtb_mode_t'(ctrl_r[`RTB_CTRL_MODE_HI:`RTB_CTRL_MODE_LO]);
  assign aps_allowed = (mode == RTB_MODE_ATM_UNI) | (mode == RTB_MODE_PPP);
  assign aps_role = aps_en & aps_allowed;
  // Marker pin is a bus input only with the bus on and APS role off
  assign bus_live = bus_en & ~aps_role;

  // --------------------------------------------------------------------
  // Byte capture and checks
  // --------------------------------------------------------------------
  wire logic fall_edge;
  wire logic data_par;
  wire logic cover_par;
  wire logic par_err;
  wire logic is_c1j0;
  wire rtb_trib_t cur_trib;
  rtb_trib_t trib_r;

  // Edge is looked for only while the bus is live, so a stray clock
  // on a disabled bus captures nothing
  assign fall_edge = bus_live & clk_prev_r & ~s_clk;
  assign data_par = ^s_data;
  assign cover_par = par_all ? (data_par ^ s_pl ^ s_mark) : data_par;
  assign par_err = cover_par ^ s_par ^ par_odd;
  // A marked overhead byte is C1/J0; a marked payload byte is J1
  assign is_c1j0 = s_mark & ~s_pl;
  assign cur_trib = is_c1j0 ? 2'h0 : trib_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trib_r <= 2'h0;
    end else if (ce && fall_edge) begin
      trib_r <= rtb_next_trib(cur_trib);
    end
  end

  // --------------------------------------------------------------------
  // Per-tributary path AIS
  // --------------------------------------------------------------------
  logic [NUM_TRIB-1:0] ais_r;
  wire logic [NUM_TRIB-1:0] ais_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TRIB; gi++) begin : g_ais
      // Follows the alarm of this tributary's latest byte while the bus is live, clears otherwise
      assign ais_nxt[gi] = (fall_edge && cur_trib == rtb_trib_t'(gi)) ?
                           s_alarm : (bus_live & ais_r[gi]);
    end
  endgenerate

  // One process owns the whole vector, so no bit has two drivers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ais_r <= '0;
    end else if (ce) begin
      ais_r <= ais_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Byte stream buffer
  // --------------------------------------------------------------------
  localparam int BW = 11;
  wire logic buf_in_ready;
  wire logic [BW-1:0] buf_out;
  wire logic overrun;

  // The link cannot be stalled; a byte that finds the buffer full is
  // dropped and reported instead
  assign overrun = fall_edge & ~buf_in_ready;

  rtb_buf2 #(.W(BW)) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .in_valid(fall_edge),
    .in_ready(buf_in_ready),
    .in_data({s_alarm, s_mark, s_pl, s_data}),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(buf_out)
  );

  assign byte_data = buf_out[7:0];
  assign byte_is_payload = buf_out[8];
  assign byte_phase_marker = buf_out[9];
  assign byte_alarm = buf_out[10];

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------
  logic [7:0] stat_r;
  logic [7:0] rdata_r;
  logic aps_role_r;
  logic [NUM_TRIB-1:0] ais_out_r;
  wire logic wr_ctrl;
  wire logic wr_stat;
  wire logic [7:0] stat_set;
  wire logic [7:0] stat_nxt;

  assign wr_ctrl = reg_wr_en & (reg_addr == `RTB_CTRL_ADDR);
  assign wr_stat = reg_wr_en & (reg_addr == `RTB_STAT_ADDR);
  assign stat_set = {3'h0, ais_r, overrun, fall_edge & par_err};
  // Write one to clear; a new event in the same cycle wins
  assign stat_nxt = (stat_r & ~(wr_stat ? reg_wdata : 8'h00)) | stat_set;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= `RTB_CTRL_RST;
      stat_r <= `RTB_STAT_RST;
      rdata_r <= 8'h00;
      aps_role_r <= 1'b0;
      ais_out_r <= '0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_r <= reg_wdata;
      stat_r <= stat_nxt;
      aps_role_r <= aps_role;
      ais_out_r <= ais_r;
      if (reg_rd_en) begin
        rdata_r <= (reg_addr == `RTB_CTRL_ADDR) ? ctrl_r :
                   (reg_addr == `RTB_STAT_ADDR) ? stat_r : 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign aps_role_active = aps_role_r;
  assign path_alarm_indication = ais_out_r;

endmodule // rtb_rx_bus

`default_nettype wire

// ==== rtb_params.svh ====
// Constants for the receive telecom bus input block.
// Assumes inclusion by bare name from the design files.
`ifndef RTB_PARAMS_SVH
`define RTB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define RTB_ADDR_W 16
`define RTB_CTRL_ADDR 16'h0137
`define RTB_STAT_ADDR 16'h0138
`define RTB_CTRL_RST 8'h00
`define RTB_STAT_RST 8'h00

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define RTB_CTRL_BUS_EN 0
`define RTB_CTRL_PAR_ODD 1
`define RTB_CTRL_PAR_ALL 2
`define RTB_CTRL_APS_EN 3
`define RTB_CTRL_MODE_LO 4
`define RTB_CTRL_MODE_HI 5

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define RTB_STAT_PAR_ERR 0
`define RTB_STAT_OVERRUN 1
`define RTB_STAT_AIS_LO 2
`define RTB_STAT_AIS_HI 4

// ----------------------------------------------------------------------
// Structure and timing
// ----------------------------------------------------------------------
`define RTB_NUM_TRIB 3
`define RTB_LINK_CLK_KHZ 19440
`define RTB_SYNC_STAGES 2

`endif

// ==== rtb_pkg.sv ====
// Types shared by the receive telecom bus input block.
// Assumes rtb_params.svh is available on the include path.
`default_nettype none
`include "rtb_params.svh"

package rtb_pkg;

  typedef enum logic [1:0] {
    RTB_MODE_MAPPER = 2'b00,
    RTB_MODE_ATM_UNI = 2'b01,
    RTB_MODE_PPP = 2'b10,
    RTB_MODE_RSVD = 2'b11
  } rtb_mode_t;

  typedef logic [1:0] rtb_trib_t;

  // Tributary of the byte after the one that carries index cur
  function automatic rtb_trib_t rtb_next_trib(input rtb_trib_t cur);
    rtb_trib_t last;
    last = rtb_trib_t'(`RTB_NUM_TRIB - 1);
    rtb_next_trib = (cur == last) ? 2'h0 : rtb_trib_t'(cur + 2'h1);
  endfunction

endpackage : rtb_pkg

`default_nettype wire

// ==== rtb_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none

module rtb_buf2 #(
  parameter int W = 11
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  if (W < 1) begin : g_bad_w
    $error("rtb_buf2: W must be at least 1");
  end

  logic out_valid_r;
  logic [W-1:0] out_data_r;
  logic skid_valid_r;
  logic [W-1:0] skid_data_r;
  wire logic head_free;
  wire logic take_in;

  assign head_free = out_ready | ~out_valid_r;
  assign take_in = in_valid & ~skid_valid_r;
  assign in_ready = ~skid_valid_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      skid_valid_r <= 1'b0;
      skid_data_r <= '0;
    end else if (ce) begin
      if (head_free) begin
        // Skid entry drains first so bytes keep their order
        if (skid_valid_r) begin
          out_valid_r <= 1'b1;
          out_data_r <= skid_data_r;
          skid_valid_r <= 1'b0;
        end else begin
          out_valid_r <= in_valid;
          if (in_valid) out_data_r <= in_data;
        end
      end else if (take_in) begin
        skid_valid_r <= 1'b1;
        skid_data_r <= in_data;
      end
    end
  end

endmodule // rtb_buf2

`default_nettype wire

// ==== rtb_rx_asserts.sv ====
// Port-level checks for rtb_rx_bus, bound into every instance.
// Assumes rtb_params.svh on the include path and one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
`include "rtb_params.svh"
module rtb_rx_asserts #(
  parameter int NUM_TRIB = `RTB_NUM_TRIB
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic rx_bus_clock,
  input wire logic [7:0] rx_bus_data,
  input wire logic rx_payload_indicator,
  input wire logic rx_frame_phase_marker,
  input wire logic rx_bus_parity_in,
  input wire logic rx_bus_alarm,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`RTB_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic byte_is_payload,
  input wire logic byte_phase_marker,
  input wire logic byte_alarm,
  input wire logic [NUM_TRIB-1:0] path_alarm_indication,
  input wire logic aps_role_active
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !ce);
  sequence s_wr_ctrl;
    reg_wr_en && reg_addr == `RTB_CTRL_ADDR;
  endsequence
  sequence s_rd_ctrl;
    reg_rd_en && !reg_wr_en && reg_addr == `RTB_CTRL_ADDR;
  endsequence
  a_ctrl_readback: assert property (
    s_wr_ctrl ##1 !reg_wr_en ##1 s_rd_ctrl
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("ctrl readback");
  a_unmapped_zero: assert property (
    reg_rd_en && reg_addr != `RTB_CTRL_ADDR
    && reg_addr != `RTB_STAT_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
  a_byte_after_fall: assert property (
    $rose(byte_valid) |->
    ($past(rx_bus_clock, 4) && !$past(rx_bus_clock, 3)) ||
    ($past(rx_bus_clock, 5) && !$past(rx_bus_clock, 4)) ||
    ($past(rx_bus_clock, 6) && !$past(rx_bus_clock, 5)))
    else $error("byte without link fall");
  a_link_idle_quiet: assert property (
    $stable(rx_bus_clock)[*7]
    |-> !$rose(byte_valid)) else $error("byte while link still");
  a_stall_holds: assert property (
    byte_valid && !byte_ready |=> byte_valid
    && $stable({byte_data, byte_is_payload, byte_phase_marker, byte_alarm}))
    else $error("stalled byte lost");
  a_aps_blocks_bus: assert property (
    aps_role_active[*6]
    |-> !$rose(byte_valid)) else $error("byte taken in aps role");
  a_ais_declared: assert property (
    $rose(byte_valid) && byte_alarm
    |-> ##[0:2] path_alarm_indication != '0)
    else $error("path alarm not declared");
endmodule // rtb_rx_asserts
bind rtb_rx_bus rtb_rx_asserts #(.NUM_TRIB(NUM_TRIB)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .rx_bus_clock(rx_bus_clock),
  .rx_bus_data(rx_bus_data), .rx_payload_indicator(rx_payload_indicator),
  .rx_frame_phase_marker(rx_frame_phase_marker),
  .rx_bus_parity_in(rx_bus_parity_in), .rx_bus_alarm(rx_bus_alarm),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .byte_valid(byte_valid),
  .byte_ready(byte_ready), .byte_data(byte_data),
  .byte_is_payload(byte_is_payload), .byte_phase_marker(byte_phase_marker),
  .byte_alarm(byte_alarm), .path_alarm_indication(path_alarm_indication),
  .aps_role_active(aps_role_active));
`default_nettype wire

// ==== rtb_src_model.sv ====
// Upstream telecom bus source, one byte per call of send_byte.
// Assumes the bench sets odd_sel to match its control write; all_sel may differ from it to force parity errors.
`timescale 1ns/1ps
`default_nettype none
module rtb_src_model (
  input wire logic odd_sel,
  input wire logic all_sel,
  output var logic bus_clock,
  output var logic [7:0] bus_data,
  output var logic pl,
  output var logic mk,
  output var logic par,
  output var logic alarm
);
  // ------
  // Driver
  // ------
  initial {bus_clock, bus_data, pl, mk, par, alarm} = '0;
  // Clock stands still between bytes; lines turn over once hold has passed
  task automatic send_byte(input logic [7:0] d, input logic p, m, a, bad);
    bus_data = d;
    pl = p;
    mk = m;
    alarm = a;
    par = ^d ^ (all_sel & (p ^ m)) ^ odd_sel ^ bad;
    #16 bus_clock = 1'b1;
    #32 bus_clock = 1'b0;
    // Turn over after three system edges, end off the system clock edge
    #12 {bus_data, pl, mk, par, alarm} = ~{bus_data, pl, mk, par, alarm};
    #5;
  endtask
endmodule // rtb_src_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for rtb_rx_bus driven by the upstream source model.
// Assumes design, checker and model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "rtb_params.svh"
module tb_top;
  typedef struct packed {
    logic [7:0] ctrl; logic m_all; logic bad; logic [7:0] d; logic pl, mk;
  } rtb_row_t;
  logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, byte_ready = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, r;
  logic odd_sel = 1'b0, all_sel = 1'b0;
  logic [10:0] v;
  wire rx_bus_clock, rx_payload_indicator, rx_frame_phase_marker;
  wire rx_bus_parity_in, rx_bus_alarm, byte_valid, byte_is_payload;
  wire byte_phase_marker, byte_alarm, aps_role_active;
  wire [7:0] rx_bus_data, reg_rdata, byte_data;
  wire [2:0] path_alarm_indication;
  int num_errors = 0, comparisons = 0, cycles = 0;
  rtb_row_t rows [6];
  rtb_src_model src (.odd_sel(odd_sel), .all_sel(all_sel),
    .bus_clock(rx_bus_clock), .bus_data(rx_bus_data),
    .pl(rx_payload_indicator), .mk(rx_frame_phase_marker),
    .par(rx_bus_parity_in), .alarm(rx_bus_alarm));
  rtb_rx_bus DUT (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .rx_bus_clock(rx_bus_clock), .rx_bus_data(rx_bus_data),
    .rx_payload_indicator(rx_payload_indicator),
    .rx_frame_phase_marker(rx_frame_phase_marker),
    .rx_bus_parity_in(rx_bus_parity_in), .rx_bus_alarm(rx_bus_alarm),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data),
    .byte_is_payload(byte_is_payload), .byte_phase_marker(byte_phase_marker),
    .byte_alarm(byte_alarm), .path_alarm_indication(path_alarm_indication),
    .aps_role_active(aps_role_active));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr_en = 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1 reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask
  // Bounded wait, then one handshake; the byte is read before it is taken
  task take(output logic [10:0] q);
    int i;
    i = 0;
    @(posedge clk_sys);
    #1;
    while (byte_valid !== 1'b1 && i < 40) begin
      @(posedge clk_sys);
      #1 i++;
    end
    q = {byte_alarm, byte_phase_marker, byte_is_payload, byte_data};
    byte_ready = 1'b1;
    @(posedge clk_sys);
    #1 byte_ready = 1'b0;
  endtask
  task end_of_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    rows[0] = '{8'hc1, 1'b0, 1'b0, 8'h3c, 1'b1, 1'b0};
    rows[1] = '{8'h03, 1'b0, 1'b1, 8'ha5, 1'b0, 1'b0};
    rows[2] = '{8'h05, 1'b1, 1'b0, 8'hf6, 1'b0, 1'b1};
    rows[3] = '{8'h07, 1'b1, 1'b1, 8'h01, 1'b1, 1'b1};
    rows[4] = '{8'h05, 1'b0, 1'b0, 8'h80, 1'b1, 1'b0};
    rows[5] = '{8'h01, 1'b1, 1'b0, 8'h7e, 1'b0, 1'b1};
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    foreach (rows[i]) begin
      wr(`RTB_CTRL_ADDR, rows[i].ctrl);
      odd_sel = rows[i].ctrl[1];
      all_sel = rows[i].m_all;
      src.send_byte(rows[i].d, rows[i].pl, rows[i].mk, 1'b0, rows[i].bad);
      take(v);
      chk(v, {1'b0, rows[i].mk, rows[i].pl, rows[i].d});
      rd(`RTB_STAT_ADDR, r);
      chk(r[0], rows[i].bad ^ ((rows[i].m_all ^ rows[i].ctrl[2])
        & (rows[i].pl ^ rows[i].mk)));
      wr(`RTB_STAT_ADDR, 8'hff);
    end
    $display("rows done");
    @(posedge clk_sys);
    #1 reset = 1'b1;
    @(posedge clk_sys);
    #1;
    chk({byte_valid, aps_role_active, path_alarm_indication}, 11'h000);
    reset = 1'b0;
    rd(`RTB_CTRL_ADDR, r);
    chk(r, `RTB_CTRL_RST);
    rd(`RTB_STAT_ADDR, r);
    chk(r, `RTB_STAT_RST);
    rd(16'h0139, r);
    chk(r, 8'h00);
    odd_sel = 1'b0;
    all_sel = 1'b0;
    src.send_byte(8'h42, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge clk_sys);
    #1;
    chk(byte_valid, 1'b0);
    $display("reset and disabled bus done");
    for (int m = 0; m < 4; m++) begin
      wr(`RTB_CTRL_ADDR, 8'h09 | 8'(m << 4));
      rd(`RTB_CTRL_ADDR, r);
      chk(r, 8'h09 | 8'(m << 4));
      chk(aps_role_active, m == 1 || m == 2);
      src.send_byte(8'h5a, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge clk_sys);
      #1;
      chk(byte_valid, !(m == 1 || m == 2));
      if (byte_valid === 1'b1) begin
        take(v);
        chk(v, {3'b001, 8'h5a});
      end
    end
    $display("modes done");
    wr(`RTB_CTRL_ADDR, 8'h01);
    src.send_byte(8'h11, 1'b0, 1'b1, 1'b1, 1'b0);
    src.send_byte(8'h22, 1'b1, 1'b0, 1'b0, 1'b0);
    src.send_byte(8'h33, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(`RTB_STAT_ADDR, r);
    chk(r & 8'h1e, 8'h06);
    chk(path_alarm_indication, 3'b001);
    take(v);
    chk(v, {3'b110, 8'h11});
    take(v);
    chk(v, {3'b001, 8'h22});
    chk(byte_valid, 1'b0);
    $display("stall and alarm done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
